/* File: verilog/rcsl_top.sv */
// reset-cause recording, power-up release and clock-fail switch logic
`timescale 1ns/1ps
`include "rcsl_params.svh"
// What this block does
// - power-on sets only power-on flag, restart at zero vector
// - pin reset running sets external, clears software, watchdog, idle, sleep
// - software reset sets its flag, clears external, watchdog, idle, sleep
// - pin reset asleep sets external and sleep, clears watchdog and idle
// - pin reset idle sets external and idle, clears watchdog and sleep
// - watchdog timeout running resets, sets its flag, clears four others
// - interrupt wake from sleep sets sleep flag, branches to its vector
// - monitor on, clock bad after timers, core not asleep: trap to vector four, flags kept
// - clock-fail trap moves system clock to the fast RC oscillator
// - illegal operation restarts at zero and sets illegal-operation flag
// - power-on and power-up timers never wait for the oscillator
// - monitor and power-up timer both off: leave reset after power-on delay
// - monitor off and clock absent: stay halted at reset vector
// - flags read and written by software; untouched flags keep value
// - watchdog counts freely, whatever the main oscillator does
// - watchdog timeout asleep wakes, sets sleep and watchdog flags
// - power-up delay selectable as zero, 4, 16 or 64 ms
// - clock failure loads fast RC selection, sets fail flag, clears request
module rcsl_top #(
    parameter int unsigned POWER_UP_TIMER_A_CYC = `RCSL_MS_TO_CYC(`RCSL_POWER_UP_TIMER_A_MS),
    parameter int unsigned POWER_UP_TIMER_B_CYC = `RCSL_MS_TO_CYC(`RCSL_POWER_UP_TIMER_B_MS),
    parameter int unsigned POWER_UP_TIMER_C_CYC = `RCSL_MS_TO_CYC(`RCSL_POWER_UP_TIMER_C_MS),
    parameter int unsigned WDT_CYC    = `RCSL_WDT_TOUT_CYC,
    parameter int unsigned CNT_W      = 24
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // wishbone slave
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [31:0]           wb_dat_i,
    input  wire logic                  wb_we_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    // pins and oscillator status, asynchronous
    input  wire logic                  master_clear_pin_n_i,
    input  wire logic                  osc_running_i,
    input  wire logic                  ost_expired_i,
    input  wire logic                  pll_locked_i,
    // static configuration
    input  wire logic                  fail_safe_clock_monitor_en_i,
    input  wire logic [1:0]            power_up_timer_sel_i,
    // processor core
    input  wire rcsl_pkg::rcsl_cpu_evt_t cpu_evt_i,
    output logic                       sys_reset_o,
    output logic                       cpu_halt_o,
    output logic                       restart_o,
    output logic                       cfail_trap_o,
    output logic                       wake_o,
    output logic                       wake_isr_o,
    output logic [23:0]                restart_vector_o,
    output logic [2:0]                 clk_sel_o,
    output logic                       irq_o
);
    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    logic [3:0]           pin_meta_reg;
    logic [3:0]           pin_sync_reg;
    // two flops for every asynchronous pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta_reg <= 4'hf;
            pin_sync_reg <= 4'hf;
        end else begin
            pin_meta_reg <= {master_clear_pin_n_i, osc_running_i, ost_expired_i, pll_locked_i};
            pin_sync_reg <= pin_meta_reg;
        end
    end
    logic                 osc_ok;
    // oscillator good only when running, timed out and locked
    assign osc_ok = pin_sync_reg[2] & pin_sync_reg[1] & pin_sync_reg[0];

    // ****************************************************************
    // master-clear noise filter
    // ****************************************************************
    logic [2:0]           master_clear_pin_cnt_reg;
    logic                 master_clear_pin_low_reg;
    logic                 master_clear_pin_evt;
    // short pulses never reach the counter's end, so they are ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            master_clear_pin_cnt_reg <= 3'h0;
            master_clear_pin_low_reg <= 1'b0;
        end else if (pin_sync_reg[3] == ~master_clear_pin_low_reg) begin
            master_clear_pin_cnt_reg <= 3'h0;
        end else if (master_clear_pin_cnt_reg == 3'(`RCSL_MASTER_CLEAR_PIN_FILT_CYC - 1)) begin
            master_clear_pin_cnt_reg <= 3'h0;
            master_clear_pin_low_reg <= ~master_clear_pin_low_reg;
        end else begin
            master_clear_pin_cnt_reg <= master_clear_pin_cnt_reg + 3'h1;
        end
    end
    // event fires once on the filtered falling edge
    assign master_clear_pin_evt = ~master_clear_pin_low_reg & ~pin_sync_reg[3]
                    & (master_clear_pin_cnt_reg == 3'(`RCSL_MASTER_CLEAR_PIN_FILT_CYC - 1));

    // ****************************************************************
    // power-up sequencer
    // ****************************************************************
    rcsl_pkg::rcsl_state_t state_reg;
    rcsl_pkg::rcsl_state_t state_next;
    logic [CNT_W-1:0]     tmr_reg;
    logic [CNT_W-1:0]     power_up_timer_len;
    logic                 tmr_done;
    logic [2:0]           cur_osc_reg;
    logic                 cfail_evt;
    // delay picked from the configuration strap
    always_comb begin
        case (power_up_timer_sel_i)
            2'h0:    power_up_timer_len = '0;
            2'h1:    power_up_timer_len = CNT_W'(POWER_UP_TIMER_A_CYC);
            2'h2:    power_up_timer_len = CNT_W'(POWER_UP_TIMER_B_CYC);
            default: power_up_timer_len = CNT_W'(POWER_UP_TIMER_C_CYC);
        endcase
    end
    // timers look only at elapsed cycles, never at the oscillator
    always_comb begin
        case (state_reg)
            rcsl_pkg::ST_POR:
                tmr_done = (tmr_reg >= CNT_W'(`RCSL_TPOR_CYC - 1));
            rcsl_pkg::ST_POWER_UP_TIMER:
                tmr_done = (tmr_reg + CNT_W'(1) >= power_up_timer_len);
            default:
                tmr_done = 1'b0;
        endcase
    end
    // state transitions
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            rcsl_pkg::ST_POR: begin
                if (tmr_done) state_next = rcsl_pkg::ST_POWER_UP_TIMER;
            end
            rcsl_pkg::ST_POWER_UP_TIMER: begin
                // zero delay selection passes straight through
                if (tmr_done || power_up_timer_len == '0) begin
                    if (!osc_ok && !fail_safe_clock_monitor_en_i)
                        state_next = rcsl_pkg::ST_HALT;
                    else
                        state_next = rcsl_pkg::ST_RUN;
                end
            end
            rcsl_pkg::ST_HALT: begin
                if (osc_ok || fail_safe_clock_monitor_en_i)
                    state_next = rcsl_pkg::ST_RUN;
            end
            rcsl_pkg::ST_RUN: state_next = rcsl_pkg::ST_RUN;
            default:          state_next = rcsl_pkg::ST_POR;
        endcase
    end
    // state and delay counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= rcsl_pkg::ST_POR;
            tmr_reg   <= '0;
        end else begin
            state_reg <= state_next;
            if (state_next != state_reg)
                tmr_reg <= '0;
            else
                tmr_reg <= tmr_reg + CNT_W'(1);
        end
    end
    // the monitor is blind in sleep, since no clock is running there
    assign cfail_evt = fail_safe_clock_monitor_en_i & ~osc_ok
                     & (state_reg == rcsl_pkg::ST_RUN)
                     & ~cpu_evt_i.sleep_mode
                     & (cur_osc_reg != `RCSL_OSC_FRC);

    // ****************************************************************
    // watchdog
    // ****************************************************************
    logic [CNT_W-1:0]     wdt_reg;
    logic                 wdt_en_reg;
    logic                 wdt_evt;
    // free-running on the block clock, blind to the oscillator status
    always_ff @(posedge clk_i) begin
        if (rst_i || !wdt_en_reg || cpu_evt_i.wdt_clear || wdt_evt)
            wdt_reg <= '0;
        else
            wdt_reg <= wdt_reg + CNT_W'(1);
    end
    assign wdt_evt = wdt_en_reg && (wdt_reg == CNT_W'(WDT_CYC - 1));

    // ****************************************************************
    // reset-cause flags
    // ****************************************************************
    rcsl_pkg::rcsl_cause_t cause_reg;
    rcsl_pkg::rcsl_cause_t cause_next;
    logic                 bus_req;
    logic                 bus_wr;
    logic                 bus_rd;
    logic                 in_sleep;
    logic                 in_idle;
    logic                 wdt_wake;
    logic                 wdt_rst;
    logic                 irq_wake;
    logic                 any_restart;
    // writes land at the edge where the master sees ack, not one earlier
    assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr   = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
    assign bus_rd   = bus_req & ~wb_we_i;
    assign in_sleep = cpu_evt_i.sleep_mode;
    assign in_idle  = cpu_evt_i.idle_mode & ~in_sleep;
    assign wdt_wake = wdt_evt & (in_sleep | in_idle);
    assign wdt_rst  = wdt_evt & ~in_sleep & ~in_idle;
    assign irq_wake = cpu_evt_i.wake_irq & in_sleep;
    assign any_restart = master_clear_pin_evt | cpu_evt_i.sw_reset | wdt_rst
                       | cpu_evt_i.trap_conflict | cpu_evt_i.illegal_op;
    // software write first, hardware events on top so a set wins
    always_comb begin
        cause_next = cause_reg;
        if (bus_wr && wb_adr_i == `RCSL_ADR_CAUSE)
            cause_next = rcsl_pkg::rcsl_cause_t'(wb_dat_i[7:0]);
        if (master_clear_pin_evt) begin
            cause_next.external_pin_reset_flag = 1'b1;
            cause_next.watchdog_timeout_flag   = 1'b0;
            if (in_sleep) begin
                cause_next.sleep_flag = 1'b1;
                cause_next.idle_flag  = 1'b0;
            end else if (in_idle) begin
                cause_next.idle_flag  = 1'b1;
                cause_next.sleep_flag = 1'b0;
            end else begin
                cause_next.software_reset_flag = 1'b0;
                cause_next.idle_flag           = 1'b0;
                cause_next.sleep_flag          = 1'b0;
            end
        end
        if (cpu_evt_i.sw_reset) begin
            cause_next.software_reset_flag     = 1'b1;
            cause_next.external_pin_reset_flag = 1'b0;
            cause_next.watchdog_timeout_flag   = 1'b0;
            cause_next.idle_flag               = 1'b0;
            cause_next.sleep_flag              = 1'b0;
        end
        if (wdt_rst) begin
            cause_next.watchdog_timeout_flag   = 1'b1;
            cause_next.external_pin_reset_flag = 1'b0;
            cause_next.software_reset_flag     = 1'b0;
            cause_next.idle_flag               = 1'b0;
            cause_next.sleep_flag              = 1'b0;
        end
        if (wdt_wake) begin
            cause_next.watchdog_timeout_flag = 1'b1;
            if (in_sleep) cause_next.sleep_flag = 1'b1;
            if (in_idle)  cause_next.idle_flag  = 1'b1;
        end
        if (irq_wake)
            cause_next.sleep_flag = 1'b1;
        if (cpu_evt_i.trap_conflict)
            cause_next.trap_conflict_flag = 1'b1;
        if (cpu_evt_i.illegal_op)
            cause_next.illegal_op_flag = 1'b1;
    end
    // power-on leaves only the power-on flag standing
    always_ff @(posedge clk_i) begin
        if (rst_i)
            cause_reg <= rcsl_pkg::rcsl_cause_t'(8'h01);
        else
            cause_reg <= cause_next;
    end

    // ****************************************************************
    // oscillator control and clock-fail switch
    // ****************************************************************
    logic                 cf_flag_reg;
    logic                 sw_req_reg;
    logic                 osc_wr;
    assign osc_wr = bus_wr && wb_adr_i == `RCSL_ADR_OSC;
    // hardware switch to the fast RC overrides a same-cycle write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_osc_reg <= `RCSL_OSC_PRI;
            cf_flag_reg <= 1'b0;
            sw_req_reg  <= 1'b0;
        end else if (cfail_evt) begin
            cur_osc_reg <= `RCSL_OSC_FRC;
            cf_flag_reg <= 1'b1;
            sw_req_reg  <= 1'b0;
        end else if (osc_wr) begin
            cur_osc_reg <= wb_dat_i[`RCSL_OSC_CUR_LSB +: 3];
            cf_flag_reg <= wb_dat_i[`RCSL_OSC_CF_BIT];
            sw_req_reg  <= wb_dat_i[`RCSL_OSC_REQ_BIT];
        end
    end

    // ****************************************************************
    // core-facing outputs
    // ****************************************************************
    // every output is a flop; restarts and the trap are one-cycle pulses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_reset_o      <= 1'b1;
            cpu_halt_o       <= 1'b0;
            restart_o        <= 1'b0;
            cfail_trap_o     <= 1'b0;
            wake_o           <= 1'b0;
            wake_isr_o       <= 1'b0;
            restart_vector_o <= `RCSL_VEC_RESET;
        end else begin
            sys_reset_o  <= (state_next == rcsl_pkg::ST_POR)
                          | (state_next == rcsl_pkg::ST_POWER_UP_TIMER)
                          | master_clear_pin_low_reg | master_clear_pin_evt;
            cpu_halt_o   <= (state_next == rcsl_pkg::ST_HALT);
            restart_o    <= any_restart
                          | (state_reg != rcsl_pkg::ST_RUN
                             && state_next == rcsl_pkg::ST_RUN);
            cfail_trap_o <= cfail_evt;
            wake_o       <= wdt_wake | irq_wake;
            wake_isr_o   <= irq_wake & ~wdt_wake;
            if (any_restart)
                restart_vector_o <= `RCSL_VEC_RESET;
            else if (cfail_evt)
                restart_vector_o <= `RCSL_VEC_CFAIL;
        end
    end
    assign clk_sel_o = cur_osc_reg;

    // ****************************************************************
    // interrupt status and mask
    // ****************************************************************
    logic [`RCSL_IRQ_W-1:0] istat_reg;
    logic [`RCSL_IRQ_W-1:0] imask_reg;
    logic [`RCSL_IRQ_W-1:0] irq_set;
    logic                   istat_rd;
    assign irq_set  = {any_restart, wdt_evt, cfail_evt};
    assign istat_rd = bus_rd && wb_adr_i == `RCSL_ADR_ISTAT;
    // read clears, a new event in the same cycle survives it
    always_ff @(posedge clk_i) begin
        if (rst_i)
            istat_reg <= '0;
        else if (istat_rd)
            istat_reg <= irq_set;
        else
            istat_reg <= istat_reg | irq_set;
    end
    // mask and watchdog enable written by software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            imask_reg  <= '0;
            wdt_en_reg <= 1'b0;
        end else begin
            if (bus_wr && wb_adr_i == `RCSL_ADR_IMASK)
                imask_reg <= wb_dat_i[`RCSL_IRQ_W-1:0];
            if (bus_wr && wb_adr_i == `RCSL_ADR_CTRL)
                wdt_en_reg <= wb_dat_i[0];
        end
    end
    // level interrupt, flopped on the same edge as the status bits
    always_ff @(posedge clk_i) begin
        if (rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |((istat_rd ? irq_set : (istat_reg | irq_set)) & imask_reg);
    end

    // ****************************************************************
    // wishbone slave
    // ****************************************************************
    // ack one cycle after the strobe; unmapped addresses read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_rd) begin
                case (wb_adr_i)
                    `RCSL_ADR_CAUSE: wb_dat_o <= {24'h0, cause_reg};
                    `RCSL_ADR_OSC:   wb_dat_o <= {25'h0, cur_osc_reg,
                                                  cf_flag_reg, 2'h0, sw_req_reg};
                    `RCSL_ADR_CTRL:  wb_dat_o <= {31'h0, wdt_en_reg};
                    `RCSL_ADR_ISTAT: wb_dat_o <= {29'h0, istat_reg};
                    `RCSL_ADR_IMASK: wb_dat_o <= {29'h0, imask_reg};
                    `RCSL_ADR_WDT:   wb_dat_o <= 32'(wdt_reg);
                    `RCSL_ADR_STATE: wb_dat_o <= {28'h0, state_reg};
                    default:         wb_dat_o <= 32'h0;
                endcase
            end else begin
                wb_dat_o <= 32'h0;
            end
        end
    end
endmodule : rcsl_top

/* File: verilog/rcsl_params.svh */
// constants for the reset-cause and power-up release block
`ifndef RCSL_PARAMS_SVH
`define RCSL_PARAMS_SVH
// clock and delays
`define RCSL_CLK_PERIOD_NS 10
`define RCSL_TPOR_NS       10000
`define RCSL_TPOR_CYC      ((`RCSL_TPOR_NS + `RCSL_CLK_PERIOD_NS - 1) / `RCSL_CLK_PERIOD_NS)
`define RCSL_POWER_UP_TIMER_A_MS     4
`define RCSL_POWER_UP_TIMER_B_MS     16
`define RCSL_POWER_UP_TIMER_C_MS     64
`define RCSL_MS_TO_CYC(ms) ((ms) * 1000000 / `RCSL_CLK_PERIOD_NS)
`define RCSL_MASTER_CLEAR_PIN_FILT_CYC 4
`define RCSL_WDT_TOUT_CYC  20000
// restart vectors
`define RCSL_VEC_RESET     24'h000000
`define RCSL_VEC_CFAIL     24'h000004
// oscillator selections
`define RCSL_OSC_FRC       3'h1
`define RCSL_OSC_PRI       3'h2
// register byte offsets
`define RCSL_ADR_CAUSE     8'h00
`define RCSL_ADR_OSC       8'h04
`define RCSL_ADR_CTRL      8'h08
`define RCSL_ADR_ISTAT     8'h0c
`define RCSL_ADR_IMASK     8'h10
`define RCSL_ADR_WDT       8'h14
`define RCSL_ADR_STATE     8'h18
// oscillator register fields
`define RCSL_OSC_REQ_BIT   0
`define RCSL_OSC_CF_BIT    3
`define RCSL_OSC_CUR_LSB   4
// interrupt status bits
`define RCSL_IRQ_CFAIL     0
`define RCSL_IRQ_WDT       1
`define RCSL_IRQ_RESTART   2
`define RCSL_IRQ_W         3
`endif

/* File: verilog/rcsl_pkg.sv */
// types shared by the reset-cause and power-up release block
package rcsl_pkg;
    // power-up sequencing states
    typedef enum logic [3:0] {
        ST_POR  = 4'b0001,
        ST_POWER_UP_TIMER = 4'b0010,
        ST_RUN  = 4'b0100,
        ST_HALT = 4'b1000
    } rcsl_state_t;

    // reset-cause flags, msb first
    typedef struct packed {
        logic trap_conflict_flag;
        logic illegal_op_flag;
        logic external_pin_reset_flag;
        logic software_reset_flag;
        logic watchdog_timeout_flag;
        logic sleep_flag;
        logic idle_flag;
        logic power_on_flag;
    } rcsl_cause_t;

    // requests and levels from the processor core
    typedef struct packed {
        logic sleep_mode;
        logic idle_mode;
        logic sw_reset;
        logic trap_conflict;
        logic illegal_op;
        logic wake_irq;
        logic wdt_clear;
    } rcsl_cpu_evt_t;
endpackage : rcsl_pkg

/* File: testbench/rcsl_monitor.sv */
// port checker for the reset-cause block
`timescale 1ns/1ps
// ****************************************
// checker
// ****************************************
module rcsl_monitor (
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    input wire logic                    wb_cyc_i,
    input wire logic                    wb_stb_i,
    input wire logic                    wb_ack_o,
    input wire logic                    master_clear_pin_n_i,
    input wire rcsl_pkg::rcsl_cpu_evt_t cpu_evt_i,
    input wire logic                    sys_reset_o,
    input wire logic                    restart_o,
    input wire logic                    cfail_trap_o,
    input wire logic                    wake_o,
    input wire logic                    wake_isr_o,
    input wire logic [23:0]             restart_vector_o,
    input wire logic [2:0]              clk_sel_o
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack late or longer than one cycle");
    a_por_release: assert property ($fell(rst_i) |-> sys_reset_o && restart_vector_o == 24'h0
        && clk_sel_o == 3'h2) else $error("outputs wrong at reset release");
    a_restart_vec: assert property (restart_o |-> restart_vector_o == 24'h000000)
        else $error("restart without zero vector");
    a_sw_restart: assert property (cpu_evt_i.sw_reset && !sys_reset_o |=> restart_o)
        else $error("software reset gave no restart");
    a_trap_restart: assert property (cpu_evt_i.trap_conflict && !sys_reset_o |=> restart_o)
        else $error("trap conflict gave no restart");
    a_illegal_restart: assert property (cpu_evt_i.illegal_op && !sys_reset_o |=> restart_o)
        else $error("illegal operation gave no restart");
    a_wake_branch: assert property (cpu_evt_i.wake_irq && cpu_evt_i.sleep_mode && !sys_reset_o
        |=> wake_o && wake_isr_o) else $error("interrupt wake did not branch");
    a_cfail_switch: assert property (cfail_trap_o |-> restart_vector_o == 24'h000004
        && clk_sel_o == 3'h1 ##1 !cfail_trap_o) else $error("clock fail trap vector or switch wrong");
    // a filtered low pin must reach the reset output within a few cycles
    a_pin_reset: assert property ($fell(master_clear_pin_n_i) ##1 !master_clear_pin_n_i [*6]
        |-> ##[0:4] sys_reset_o) else $error("pin reset not applied");
endmodule : rcsl_monitor

bind rcsl_top rcsl_monitor rcsl_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .master_clear_pin_n_i(master_clear_pin_n_i),
    .cpu_evt_i(cpu_evt_i), .sys_reset_o(sys_reset_o), .restart_o(restart_o),
    .cfail_trap_o(cfail_trap_o), .wake_o(wake_o), .wake_isr_o(wake_isr_o),
    .restart_vector_o(restart_vector_o), .clk_sel_o(clk_sel_o));

/* File: testbench/rcsl_top_tb.sv */
// self-checking bench for the reset-cause block
`timescale 1ns/1ps
// ****************************************
// bench
// ****************************************
module rcsl_top_tb;
    logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, pin = 1, osc = 1;
    logic wb_ack_o, sys_reset_o, restart_o, cfail_trap_o, wake_o, irq_o;
    logic fsm = 1, ost = 1, pll = 1, halt, wisr;
    logic [1:0]  psel = 2'h1;
    logic [3:0]  sel = 4'hf;
    logic [7:0]  adr = 8'h00, cm = 8'h01;
    logic [31:0] wd = 32'h0, rd, wb_dat_o;
    logic [23:0] vec;
    logic [2:0]  clk_sel_o;
    rcsl_pkg::rcsl_cpu_evt_t evt = '0;
    int n_mismatch = 0, samples_checked = 0, k;
    // short timers keep the run brief
    rcsl_top #(.POWER_UP_TIMER_A_CYC(20), .POWER_UP_TIMER_B_CYC(40), .POWER_UP_TIMER_C_CYC(80), .WDT_CYC(50)) rcsl_top_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wd), .wb_we_i(we),
        .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .master_clear_pin_n_i(pin), .osc_running_i(osc),
        .ost_expired_i(ost), .pll_locked_i(pll), .fail_safe_clock_monitor_en_i(fsm),
        .power_up_timer_sel_i(psel), .cpu_evt_i(evt), .sys_reset_o(sys_reset_o),
        .cpu_halt_o(halt), .restart_o(restart_o), .cfail_trap_o(cfail_trap_o),
        .wake_o(wake_o), .wake_isr_o(wisr),
        .restart_vector_o(vec), .clk_sel_o(clk_sel_o), .irq_o(irq_o));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // bounded wait for a level, seen at the edge
    task automatic till(ref logic s, input logic v, input int lim);
        k = 0;
        do begin @(posedge clk_i); k++; end while (s !== v && k < lim);
        chk(s, v);
    endtask : till
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1; we <= w; adr <= a; wd <= d;
        till(wb_ack_o, 1'b1, 20);
        rd = wb_dat_o;
        cyc <= 0;
    endtask : wb
    task automatic rdc;
        wb(0, 8'h00, 32'h0);
        chk(rd, {24'h0, cm});
    endtask : rdc
    // one-cycle event pulse, sleep and idle levels kept
    task automatic pulse(input logic [6:0] m);
        @(posedge clk_i);
        evt <= evt | m;
        @(posedge clk_i);
        evt <= evt & 7'h60;
    endtask : pulse
    task automatic wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    // clock
    initial forever #5 clk_i = ~clk_i;
    // hang guard, far beyond the expected run
    initial begin
        #200000;
        n_mismatch++;
        wrap_up;
    end
    // main sequence
    initial begin
        void'($urandom(32'h67ee));
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        rdc;
        till(restart_o, 1'b1, 2000);
        chk(sys_reset_o, 0);
        chk(halt, 0);
        cm = 8'($urandom);
        wb(1, 8'h00, {24'h0, cm});
        rdc;
        // a write without byte lane zero must leave the flags alone
        sel <= 4'he;
        wb(1, 8'h00, 32'h0);
        sel <= 4'hf;
        rdc;
        for (int i = 0; i < 3; i++) begin
            pulse(7'h10 >> i);
            cm = i == 0 ? cm & 8'hc1 | 8'h10 : cm | (8'h80 >> (i - 1));
            till(restart_o, 1'b1, 5);
            chk(vec, 0);
            rdc;
        end
        chk(irq_o, 0); // masked status keeps the line low
        evt <= 7'h40;
        pulse(7'h02);
        till(wake_o, 1'b1, 5);
        chk(wisr, 1);
        cm = cm | 8'h04;
        rdc;
        for (int i = 0; i < 3; i++) begin
            evt <= i == 1 ? 7'h40 : (i == 2 ? 7'h20 : 7'h00);
            @(posedge clk_i);
            pin <= 0;
            repeat (10) @(posedge clk_i);
            pin <= 1;
            cm = cm & (i > 0 ? 8'hd1 : 8'hc1) | (i == 1 ? 8'h24 : (i == 2 ? 8'h22 : 8'h20));
            till(sys_reset_o, 1'b0, 3000);
            evt <= 7'h00;
            rdc;
        end
        wb(1, 8'h08, 32'h1);
        till(restart_o, 1'b1, 300);
        wb(1, 8'h08, 32'h0);
        cm = cm & 8'hc1 | 8'h08;
        rdc;
        evt <= 7'h40;
        wb(1, 8'h08, 32'h1);
        till(wake_o, 1'b1, 300);
        chk(wisr, 0);
        wb(1, 8'h08, 32'h0);
        evt <= 7'h00;
        cm = cm | 8'h0c;
        rdc;
        wb(1, 8'h10, 32'h1);
        osc <= 0;
        till(cfail_trap_o, 1'b1, 20);
        chk(vec, 24'h000004);
        chk(clk_sel_o, 3'h1);
        till(irq_o, 1'b1, 3);
        wb(0, 8'h04, 32'h0);
        chk(rd & 32'h79, 32'h18);
        wb(0, 8'h0c, 32'h0);
        chk(rd & 32'h1, 32'h1);
        wb(0, 8'h40, 32'h0);
        chk(rd, 0);
        chk(irq_o, 0);
        rdc;
        // second power-on: monitor and delay off, lock missing until later
        rst_i <= 1;
        fsm <= 0;
        psel <= 2'h0;
        osc <= 1;
        pll <= 0;
        cm = 8'h01;
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        till(halt, 1'b1, 1100);
        chk(sys_reset_o, 0);
        pll <= 1;
        till(restart_o, 1'b1, 5);
        chk(halt, 0);
        rdc;
        wrap_up;
    end
endmodule : rcsl_top_tb
